// >>> verilog/rlpc_cfg.svh
// Register map, field positions and timing counts of the colour LED PWM block
`ifndef RLPC_CFG_SVH
`define RLPC_CFG_SVH

`define RLPC_ADDR_CTRL   8'h00
`define RLPC_ADDR_COLOUR 8'h01

`define RLPC_BIT_PWM_EN  7
`define RLPC_BIT_MASTER  6
`define RLPC_BIT_SINK_OR_SWITCH_SELECT   5
`define RLPC_BIT_RED     3
`define RLPC_BIT_GREEN   2
`define RLPC_BIT_BLUE    1
`define RLPC_BIT_OVL     0
`define RLPC_COL_HI      7
`define RLPC_COL_LO      4
`define RLPC_BR_HI       3
`define RLPC_BR_LO       1

`define RLPC_CTRL_RST    8'h20
`define RLPC_COLOUR_RST  8'h00
`define RLPC_CTRL_MASK   8'hee
`define RLPC_BR_FULL     3'h7

// Colour units per frame; thirds, quarters and halves divide it exactly
`define RLPC_FRAME_UNITS 192
`define RLPC_FRAME_CYC   12288
`define RLPC_UNIT_FULL   8'hc0
`define RLPC_UNIT_3Q     8'h90
`define RLPC_UNIT_HALF   8'h60
`define RLPC_UNIT_THIRD  8'h40
`define RLPC_UNIT_QUART  8'h30

`endif

// >>> verilog/rlpc_pkg.sv
// Types shared by the colour LED PWM block
package rlpc_pkg;
    typedef logic [7:0] rlpc_byte_t;
    typedef logic [2:0] rlpc_chan_t;
    typedef enum logic [1:0] {
        RLPC_DARK     = 2'b00,
        RLPC_DIRECT   = 2'b01,
        RLPC_OVERLAP  = 2'b10,
        RLPC_SPLIT    = 2'b11
    } rlpc_drive_t;
endpackage

// >>> verilog/rlpc_internal_pwm_enable.sv
// Colour LED output control: registers, PWM frame and output drive
`timescale 1ns/100ps
`include "rlpc_cfg.svh"

module rlpc_internal_pwm_enable #(
    parameter int FRAME_CYC = `RLPC_FRAME_CYC
) (
    // Clock and reset
    input  wire logic               clk,
    input  wire logic               reset,
    // Register port of the host interface
    input  wire logic               reg_wr,
    input  wire logic [7:0]         reg_addr,
    input  wire rlpc_pkg::rlpc_byte_t reg_wdata,
    output rlpc_pkg::rlpc_byte_t    reg_rdata,
    // External PWM pin and its per-channel selects
    input  wire logic               ext_pwm_pin,
    input  wire rlpc_pkg::rlpc_chan_t ext_pwm_sel,
    // Colour outputs
    output logic                    red_sink_out,
    output logic                    green_sink_out,
    output logic                    blue_sink_out,
    output logic                    sink_or_switch_select
);
    import rlpc_pkg::*;

    localparam int UNIT_CYC_I = FRAME_CYC / `RLPC_FRAME_UNITS;
    localparam logic [13:0] UNIT_CYC = 14'(UNIT_CYC_I);
    localparam logic [13:0] FRAME_LAST = 14'(FRAME_CYC - 1);
    localparam logic [13:0] FRAME_LEN = 14'(FRAME_CYC);

    // Register file
    rlpc_byte_t ctrl_ff, nxt_ctrl;
    rlpc_byte_t colour_ff, nxt_colour;
    rlpc_byte_t rdata_ff, nxt_rdata;

    always_comb begin
        nxt_ctrl = ctrl_ff;
        nxt_colour = colour_ff;
        nxt_rdata = 8'h00;
        if (reg_wr && reg_addr == `RLPC_ADDR_CTRL) begin
            nxt_ctrl = reg_wdata & `RLPC_CTRL_MASK;
        end
        if (reg_wr && reg_addr == `RLPC_ADDR_COLOUR) begin
            nxt_colour = reg_wdata;
        end
        // Unmapped addresses read as zero
        if (reg_addr == `RLPC_ADDR_CTRL) begin
            nxt_rdata = ctrl_ff;
        end else if (reg_addr == `RLPC_ADDR_COLOUR) begin
            nxt_rdata = colour_ff;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            ctrl_ff <= `RLPC_CTRL_RST;
            colour_ff <= `RLPC_COLOUR_RST;
            rdata_ff <= 8'h00;
        end else begin
            ctrl_ff <= nxt_ctrl;
            colour_ff <= nxt_colour;
            rdata_ff <= nxt_rdata;
        end
    end

    assign reg_rdata = rdata_ff;

    // Field decode
    logic       pwm_en;
    logic       master_en;
    logic       overlap_select;
    logic [3:0] colour_code;
    logic [2:0] bright_code;
    rlpc_chan_t chan_en;

    assign pwm_en = ctrl_ff[`RLPC_BIT_PWM_EN];
    assign master_en = ctrl_ff[`RLPC_BIT_MASTER];
    assign chan_en = {ctrl_ff[`RLPC_BIT_RED], ctrl_ff[`RLPC_BIT_GREEN],
                      ctrl_ff[`RLPC_BIT_BLUE]};
    assign overlap_select = colour_ff[`RLPC_BIT_OVL];
    assign colour_code = colour_ff[`RLPC_COL_HI:`RLPC_COL_LO];
    assign bright_code = colour_ff[`RLPC_BR_HI:`RLPC_BR_LO];

    // External pin synchroniser; a change counts once stages two and three agree
    logic s1_ff, s2_ff, s3_ff, ext_ff;
    logic nxt_ext;

    always_comb begin
        nxt_ext = ext_ff;
        if (s2_ff == s3_ff) begin
            nxt_ext = s3_ff;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            s1_ff <= 1'b0;
            s2_ff <= 1'b0;
            s3_ff <= 1'b0;
            ext_ff <= 1'b0;
        end else begin
            s1_ff <= ext_pwm_pin;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            ext_ff <= nxt_ext;
        end
    end

    // Colour code to slot lengths in frame units
    function automatic logic [23:0] colour_units(input logic [3:0] code);
        logic [7:0] f, q3, h, t, q;
        f = `RLPC_UNIT_FULL;
        q3 = `RLPC_UNIT_3Q;
        h = `RLPC_UNIT_HALF;
        t = `RLPC_UNIT_THIRD;
        q = `RLPC_UNIT_QUART;
        unique case (code)
            4'h0: colour_units = {f, 8'h00, 8'h00};
            4'h1: colour_units = {8'h00, f, 8'h00};
            4'h2: colour_units = {8'h00, 8'h00, f};
            4'h3: colour_units = {h, h, 8'h00};
            4'h4: colour_units = {8'h00, h, h};
            4'h5: colour_units = {h, 8'h00, h};
            4'h6: colour_units = {t, t, t};
            4'h7: colour_units = {h, q, q};
            4'h8: colour_units = {q, h, q};
            4'h9: colour_units = {q, h, q};
            4'ha: colour_units = {q, q, h};
            4'hb: colour_units = {q3, q, 8'h00};
            4'hc: colour_units = {8'h00, q3, q};
            4'hd: colour_units = {q, q3, 8'h00};
            4'he: colour_units = {8'h00, q, q3};
            4'hf: colour_units = {q, 8'h00, q3};
        endcase
    endfunction

    // Slot boundaries, scaled by brightness so the frame length never changes
    logic [23:0] units;
    logic [2:0]  shift;
    logic [13:0] r_len, g_len, b_len;
    logic [13:0] r_end, g_end, b_end;
    logic [13:0] duty_end;

    assign units = colour_units(colour_code);
    assign shift = `RLPC_BR_FULL - bright_code;
    assign r_len = (14'(units[23:16]) * UNIT_CYC) >> shift;
    assign g_len = (14'(units[15:8]) * UNIT_CYC) >> shift;
    assign b_len = (14'(units[7:0]) * UNIT_CYC) >> shift;
    assign r_end = r_len;
    assign g_end = r_end + g_len;
    assign b_end = g_end + b_len;
    assign duty_end = FRAME_LEN >> shift;

    // Frame counter and output drive
    logic [13:0] pos_ff, nxt_pos;
    rlpc_drive_t drive;
    rlpc_chan_t  pat, gated;
    logic        in_bright;
    logic        red_ff, green_ff, blue_ff, mode_ff;

    always_comb begin
        if (!master_en) begin
            drive = RLPC_DARK;
        end else if (!pwm_en) begin
            drive = RLPC_DIRECT;
        end else if (overlap_select) begin
            drive = RLPC_OVERLAP;
        end else begin
            drive = RLPC_SPLIT;
        end
    end

    always_comb begin
        // Code 000 is fully off even though the shifted ends are nonzero
        in_bright = bright_code != 3'h0;
        unique case (drive)
            RLPC_DARK: pat = 3'h0;
            RLPC_DIRECT: pat = chan_en;
            // Colour code is not looked at here
            RLPC_OVERLAP: pat = chan_en & {3{in_bright && pos_ff < duty_end}};
            RLPC_SPLIT: pat = chan_en & {3{in_bright}} &
                              {pos_ff < r_end,
                               pos_ff >= r_end && pos_ff < g_end,
                               pos_ff >= g_end && pos_ff < b_end};
        endcase
    end

    // Selected channels are gated by the external pin, active high
    for (genvar i = 0; i < 3; i++) begin : g_ext
        assign gated[i] = ext_pwm_sel[i] ? (pat[i] & ext_ff) : pat[i];
    end

    always_comb begin
        nxt_pos = pos_ff + 14'h0001;
        if (!pwm_en || !master_en || pos_ff == FRAME_LAST) begin
            nxt_pos = 14'h0000;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            pos_ff <= 14'h0000;
            red_ff <= 1'b0;
            green_ff <= 1'b0;
            blue_ff <= 1'b0;
            mode_ff <= 1'b1;
        end else begin
            pos_ff <= nxt_pos;
            red_ff <= gated[2];
            green_ff <= gated[1];
            blue_ff <= gated[0];
            mode_ff <= ctrl_ff[`RLPC_BIT_SINK_OR_SWITCH_SELECT];
        end
    end

    assign red_sink_out = red_ff;
    assign green_sink_out = green_ff;
    assign blue_sink_out = blue_ff;
    assign sink_or_switch_select = mode_ff;

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    a_mode_pin_follow: assert property (
        ##1 sink_or_switch_select == $past(ctrl_ff[`RLPC_BIT_SINK_OR_SWITCH_SELECT]))
        else $error("mode output does not follow control bit");

    a_master_off_dark: assert property (
        !master_en |=> !red_sink_out && !green_sink_out && !blue_sink_out)
        else $error("output on while master enable is clear");

    a_write_ctrl_take: assert property (
        reg_wr && reg_addr == `RLPC_ADDR_CTRL
        |=> ctrl_ff == ($past(reg_wdata) & `RLPC_CTRL_MASK))
        else $error("control write not stored");

    a_chan_off_dark: assert property (
        !ctrl_ff[`RLPC_BIT_RED] |=> !red_sink_out)
        else $error("red on while its enable is clear");

    a_direct_follow: assert property (
        master_en && !pwm_en && ext_pwm_sel == 3'h0
        |=> {red_sink_out, green_sink_out, blue_sink_out} == $past(chan_en))
        else $error("direct mode output differs from enables");

    a_frame_restart: assert property (
        (!pwm_en || !master_en) ##1 (pwm_en && master_en)
        |-> pos_ff == 14'h0000 ##1 pos_ff == 14'h0001)
        else $error("frame counter did not restart");

    a_slots_exclusive: assert property (
        drive == RLPC_SPLIT
        |=> $onehot0({red_sink_out, green_sink_out, blue_sink_out}))
        else $error("split slots overlap");

    a_split_tail_off: assert property (
        drive == RLPC_SPLIT && pos_ff >= b_end
        |=> !red_sink_out && !green_sink_out && !blue_sink_out)
        else $error("output on in the dark tail of the frame");

    a_bright_zero_off: assert property (
        pwm_en && bright_code == 3'h0
        |=> !red_sink_out && !green_sink_out && !blue_sink_out)
        else $error("output on at brightness code zero");

    a_overlap_together: assert property (
        drive == RLPC_OVERLAP && chan_en == 3'h7 && ext_pwm_sel == 3'h0
        |=> red_sink_out == green_sink_out && green_sink_out == blue_sink_out)
        else $error("overlap outputs not switched together");

endmodule // rlpc_internal_pwm_enable

// >>> bench/rlpc_led_model.sv
// Behavioural colour LED that totals the on-time of each sink
`timescale 1ns/100ps
module rlpc_led_model (
    // Clock and window control
    input  wire logic clk,
    input  wire logic clear,
    // Sink drive from the block
    input  wire logic red_on,
    input  wire logic green_on,
    input  wire logic blue_on,
    // Totals since the last clear
    output int        red_cnt,
    output int        green_cnt,
    output int        blue_cnt,
    output int        clash_cnt
);
    // Counts only, so any window of one frame is phase independent
    always @(posedge clk) begin
        if (clear) begin
            red_cnt <= 0;
            green_cnt <= 0;
            blue_cnt <= 0;
            clash_cnt <= 0;
        end else begin
            red_cnt <= red_cnt + int'(red_on);
            green_cnt <= green_cnt + int'(green_on);
            blue_cnt <= blue_cnt + int'(blue_on);
            clash_cnt <= clash_cnt + int'(int'(red_on) + int'(green_on) + int'(blue_on) > 1);
        end
    end
endmodule // rlpc_led_model

// >>> bench/tb.sv
// Self-checking bench for the colour LED PWM block
`timescale 1ns/100ps
module tb;
    import rlpc_pkg::*;
    localparam int FC = 1536;
    // Red, green, blue units of 192 per colour code
    localparam logic [23:0] TAB [16] = '{24'hc00000, 24'h00c000, 24'h0000c0, 24'h606000,
        24'h006060, 24'h600060, 24'h404040, 24'h603030, 24'h306030, 24'h306030,
        24'h303060, 24'h903000, 24'h009030, 24'h309000, 24'h003090, 24'h300090};
    logic       clk, reset, reg_wr, ext_pwm_pin, clear, red_o, green_o, blue_o, sw_sel;
    logic [7:0] reg_addr;
    rlpc_byte_t reg_wdata, reg_rdata;
    rlpc_chan_t ext_pwm_sel;
    int         red_cnt, green_cnt, blue_cnt, clash_cnt, errors, cmp_count;

    rlpc_internal_pwm_enable #(.FRAME_CYC(FC)) u_dut (.clk(clk), .reset(reset), .reg_wr(reg_wr),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .ext_pwm_pin(ext_pwm_pin), .ext_pwm_sel(ext_pwm_sel), .red_sink_out(red_o),
        .green_sink_out(green_o), .blue_sink_out(blue_o), .sink_or_switch_select(sw_sel));
    rlpc_led_model u_led (.clk(clk), .clear(clear), .red_on(red_o), .green_on(green_o),
        .blue_on(blue_o), .red_cnt(red_cnt), .green_cnt(green_cnt), .blue_cnt(blue_cnt),
        .clash_cnt(clash_cnt));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge clk);
        reg_wr = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(negedge clk);
        reg_addr = a;
        repeat (2) @(negedge clk);
        chk(32'(reg_rdata), 32'(e));
    endtask
    // One full frame window after the outputs settle
    task automatic meas(input int r, input int g, input int b);
        repeat (8) @(negedge clk);
        clear = 1'b1;
        @(negedge clk);
        clear = 1'b0;
        repeat (FC) @(negedge clk);
        chk(red_cnt, r);
        chk(green_cnt, g);
        chk(blue_cnt, b);
    endtask
    task automatic final_report;
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic t_regs;
        rd(8'h00, 8'h20);
        rd(8'h01, 8'h00);
        chk(32'(sw_sel), 1);
        wr(8'h00, 8'hff);
        rd(8'h00, 8'hee);
        wr(8'h05, 8'haa);
        rd(8'h05, 8'h00);
        wr(8'h01, 8'ha5);
        rd(8'h01, 8'ha5);
        wr(8'h00, 8'h00);
        repeat (3) @(negedge clk);
        chk(32'(sw_sel), 0);
        $display("test regs done");
    endtask
    task automatic t_direct;
        wr(8'h01, 8'h0e);
        for (int i = 0; i < 8; i++) begin
            wr(8'h00, 8'h40 | 8'(i << 1));
            meas(i[2] ? FC : 0, i[1] ? FC : 0, i[0] ? FC : 0);
        end
        wr(8'h00, 8'h0e);
        meas(0, 0, 0);
        wr(8'h00, 8'h8e);
        meas(0, 0, 0);
        $display("test direct done");
    endtask
    task automatic t_split;
        wr(8'h00, 8'hce);
        for (int c = 0; c < 16; c++) begin
            wr(8'h01, {c[3:0], 4'he});
            meas(TAB[c][23:16] * 8, TAB[c][15:8] * 8, TAB[c][7:0] * 8);
            chk(clash_cnt, 0);
        end
        for (int b = 0; b < 7; b++) begin
            wr(8'h01, {4'h6, b[2:0], 1'b0});
            meas(b == 0 ? 0 : 512 >> (7 - b), b == 0 ? 0 : 512 >> (7 - b),
                b == 0 ? 0 : 512 >> (7 - b));
        end
        $display("test split done");
    endtask
    task automatic t_overlap;
        wr(8'h01, 8'h0d);
        meas(FC / 2, FC / 2, FC / 2);
        wr(8'h01, 8'hfd);
        meas(FC / 2, FC / 2, FC / 2);
        wr(8'h00, 8'hca);
        meas(FC / 2, 0, FC / 2);
        $display("test overlap done");
    endtask
    task automatic t_ext;
        wr(8'h00, 8'h4e);
        ext_pwm_sel = 3'h4;
        meas(0, FC, FC);
        ext_pwm_pin = 1'b1;
        meas(FC, FC, FC);
        // Internal PWM passes to red only while the pin is high
        wr(8'h00, 8'hce);
        meas(FC / 2, FC / 2, FC / 2);
        ext_pwm_pin = 1'b0;
        meas(0, FC / 2, FC / 2);
        $display("test ext done");
    endtask

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    initial begin
        #(100000 * 100);
        errors++;
        final_report();
    end
    initial begin
        reset = 1'b1;
        reg_wr = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        ext_pwm_pin = 1'b0;
        ext_pwm_sel = 3'h0;
        clear = 1'b0;
        errors = 0;
        cmp_count = 0;
        repeat (5) @(negedge clk);
        reset = 1'b0;
        t_regs();
        t_direct();
        t_split();
        t_overlap();
        t_ext();
        final_report();
    end
endmodule // tb
